// file: rtl/sac_pkg.sv
package sac_pkg;
  localparam int DW = 8;
  localparam int CORE_PERIOD_PS = 4000;
  // aperture delay from start to input capture, least time: round up
  localparam int CAPTURE_DELAY_NS = 50;
  localparam logic [3:0] CAPTURE_CYC =
    4'((CAPTURE_DELAY_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS);
  // internal oscillator half period, nominal value of our own, round down
  localparam int OSC_HALF_NS = 125;
  localparam logic [4:0] OSC_HALF_CYC =
    5'((OSC_HALF_NS * 1000) / CORE_PERIOD_PS);
  localparam logic [3:0] CONV_EDGES = 4'd8;
  localparam logic [DW-1:0] DAC_RESET = 8'h00;
  localparam logic [DW-1:0] RESULT_RESET = 8'h00;
  localparam logic [DW-1:0] SAR_CLEAR = 8'h00;
  localparam logic [DW-1:0] SAR_MSB = 8'h80;
  // pin bundle layout through the synchroniser
  localparam int PIN_W = 16;
  localparam int B_DATA = 8;
  localparam int B_START = 7;
  localparam int B_CS = 6;
  localparam int B_RD = 5;
  localparam int B_WR = 4;
  localparam int B_DEVRST = 3;
  localparam int B_EXTCLK = 2;
  localparam int B_CMP = 1;
  localparam int B_OSCSEL = 0;
  // strobes idle high so no false edge leaves reset
  localparam logic [PIN_W-1:0] PIN_RESET = 16'h00f8;
  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SETTLE = 2'b01,
    SAC_CONV   = 2'b11
  } sac_state_t;
endpackage

// file: rtl/sac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sync (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst_n,
  input  wire logic [sac_pkg::PIN_W-1:0]   i_async,
  output logic      [sac_pkg::PIN_W-1:0]   o_sync
);
  import sac_pkg::*;
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] sync_r;
  logic [PIN_W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta_r <= PIN_RESET;
      sync_r <= PIN_RESET;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule
`default_nettype wire

// file: rtl/sac_core.sv
// Operation
// - start on falling start_convert_n, or when chip select and read go low
// - device reset pin leaves conversion alone, forces interrupt high
// - conversions proceed even if the interrupt was never cleared
// - analog_input captured about 50 ns after the start condition
// - msb decided on the second counted falling conversion-clock edge
// - clock edges inside the first 50 ns after start are not counted
// - each remaining bit decided on successive conversion-clock edges
// - at the end copy successive_approx_reg to result latch, then clear it
// - one conversion spans 8 conversion-clock cycles
// - track/hold holds from start until busy rises again
// - conversion clock used only during conversion; external may run
// - internal oscillator stops at the end, clock pin held at ground
// - dac register takes data bus on write rising edge with select low
// - select and write held low never make the dac register transparent
// - dac register loads zeros while device reset pin is low
// - busy low for the whole conversion, high when it ends
// - interrupt cleared on select or read rising at end of result read
// - during a read-started conversion, old result is driven on the bus
`timescale 1ns/1ps
`default_nettype none
module sac_core (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_start_convert_n,
  input  wire logic                     i_cs_n,
  input  wire logic                     i_rd_n,
  input  wire logic                     i_wr_n,
  input  wire logic                     i_dev_reset_n,
  input  wire logic                     i_int_osc_sel,
  input  wire logic                     i_osc_timing_capacitor,
  input  wire logic                     i_cmp_above,
  input  wire logic [sac_pkg::DW-1:0]   i_data,
  output logic      [sac_pkg::DW-1:0]   o_data,
  output logic                          o_data_oe,
  output logic                          o_busy_n,
  output logic                          o_int_n,
  output logic                          o_hold,
  output logic                          o_capture,
  output logic      [sac_pkg::DW-1:0]   o_successive_approx_reg,
  output logic      [sac_pkg::DW-1:0]   o_dac_code,
  output logic                          o_osc_timing_capacitor,
  output logic                          o_osc_timing_capacitor_oe
);
  import sac_pkg::*;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // set bit b to the comparator verdict and try the next lower bit
  function automatic logic [DW-1:0] sar_step(input logic [DW-1:0] s,
                                             input logic [2:0]    b,
                                             input logic          c);
    logic [DW-1:0] r;
    r = s;
    r[b] = c;
    if (b != 3'd0) begin
      r[b - 3'd1] = 1'b1;
    end
    return r;
  endfunction

  logic [PIN_W-1:0] pin_s;
  logic [7:0]       prev_r;
  logic [7:0]       prev_nxt;
  logic             start_n;
  logic             cs_n;
  logic             rd_n;
  logic             wr_n;
  logic             devrst_n;
  logic             ext_clk;
  logic             cmp;
  logic             osc_sel;
  logic [DW-1:0]    data_s;

  sac_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    ({i_data, i_start_convert_n, i_cs_n, i_rd_n, i_wr_n,
                  i_dev_reset_n, i_osc_timing_capacitor, i_cmp_above,
                  i_int_osc_sel}),
    .o_sync     (pin_s)
  );

  assign start_n  = pin_s[B_START];
  assign cs_n     = pin_s[B_CS];
  assign rd_n     = pin_s[B_RD];
  assign wr_n     = pin_s[B_WR];
  assign devrst_n = pin_s[B_DEVRST];
  assign ext_clk  = pin_s[B_EXTCLK];
  assign cmp      = pin_s[B_CMP];
  assign osc_sel  = pin_s[B_OSCSEL];
  assign data_s   = pin_s[B_DATA +: DW];

  logic start_req;
  logic rd_access;
  logic rd_access_end;
  logic wr_commit;

  always_comb begin
    prev_nxt = pin_s[7:0];
  end

  // read access is the and of both strobes; its end is either one rising
  assign rd_access     = ~cs_n & ~rd_n;
  assign rd_access_end = ~(prev_r[B_CS] | prev_r[B_RD]) & (cs_n | rd_n);
  assign start_req     = fell(prev_r[B_START], start_n) |
                         (rd_access & (prev_r[B_CS] | prev_r[B_RD]));
  // or of select and write rises on either trailing edge
  assign wr_commit     = rose(prev_r[B_CS] | prev_r[B_WR], cs_n | wr_n);

  // internal oscillator, an enable source on the core clock
  logic [4:0] osc_cnt_r;
  logic [4:0] osc_cnt_nxt;
  logic       osc_lvl_r;
  logic       osc_lvl_nxt;
  logic       osc_wrap;
  logic       conv_edge;
  sac_state_t state_r;
  sac_state_t state_nxt;

  assign osc_wrap = (osc_cnt_r == OSC_HALF_CYC - 5'd1);

  always_comb begin
    osc_cnt_nxt = 5'd0;
    osc_lvl_nxt = 1'b0;
    if (osc_sel && state_r != SAC_IDLE) begin
      osc_cnt_nxt = osc_wrap ? 5'd0 : osc_cnt_r + 5'd1;
      osc_lvl_nxt = osc_wrap ? ~osc_lvl_r : osc_lvl_r;
    end
  end

  // the pin is an input in external mode, so edges are taken only in conv
  assign conv_edge = (state_r == SAC_CONV) &
                     (osc_sel ? (osc_lvl_r & osc_wrap)
                              : fell(prev_r[B_EXTCLK], ext_clk));

  // conversion sequencer; the device reset pin is deliberately not here
  logic [3:0]    cap_cnt_r;
  logic [3:0]    cap_cnt_nxt;
  logic [3:0]    edge_cnt_r;
  logic [3:0]    edge_cnt_nxt;
  logic [DW-1:0] sar_r;
  logic [DW-1:0] sar_nxt;
  logic [DW-1:0] result_r;
  logic [DW-1:0] result_nxt;
  logic          capture_r;
  logic          capture_nxt;
  logic          busy_n_r;
  logic          busy_n_nxt;
  logic          hold_r;
  logic          hold_nxt;
  logic          done;
  logic [DW-1:0] sar_try;

  assign sar_try = sar_step(sar_r, 3'(CONV_EDGES - edge_cnt_r), cmp);

  always_comb begin
    state_nxt    = state_r;
    cap_cnt_nxt  = cap_cnt_r;
    edge_cnt_nxt = edge_cnt_r;
    sar_nxt      = sar_r;
    result_nxt   = result_r;
    capture_nxt  = 1'b0;
    done         = 1'b0;
    case (state_r)
      SAC_IDLE: begin
        // no look at the interrupt: an uncleared one never blocks a start
        if (start_req) begin
          state_nxt    = SAC_SETTLE;
          cap_cnt_nxt  = 4'd0;
          edge_cnt_nxt = 4'd0;
        end
      end
      SAC_SETTLE: begin
        // clock edges here fall inside the aperture window and are dropped
        if (cap_cnt_r == CAPTURE_CYC - 4'd1) begin
          state_nxt   = SAC_CONV;
          capture_nxt = 1'b1;
        end else begin
          cap_cnt_nxt = cap_cnt_r + 4'd1;
        end
      end
      SAC_CONV: begin
        if (conv_edge) begin
          if (edge_cnt_r == 4'd0) begin
            sar_nxt      = SAR_MSB;
            edge_cnt_nxt = 4'd1;
          end else if (edge_cnt_r == CONV_EDGES) begin
            done       = 1'b1;
            result_nxt = sar_try;
            sar_nxt    = SAR_CLEAR;
            state_nxt  = SAC_IDLE;
          end else begin
            sar_nxt      = sar_try;
            edge_cnt_nxt = edge_cnt_r + 4'd1;
          end
        end
      end
      default: begin
        state_nxt = SAC_IDLE;
      end
    endcase
    // starts during a conversion are simply not looked at
    busy_n_nxt = (state_nxt == SAC_IDLE);
    hold_nxt   = (state_nxt != SAC_IDLE);
  end

  // interrupt: a fresh result wins over any clear in the same cycle
  logic int_n_r;
  logic int_n_nxt;

  always_comb begin
    int_n_nxt = int_n_r;
    if (done) begin
      int_n_nxt = 1'b0;
    end else if (!devrst_n || rd_access_end) begin
      int_n_nxt = 1'b1;
    end
  end

  // dac register loads the bus on an edge only, never while strobes sit low
  logic [DW-1:0] dac_r;
  logic [DW-1:0] dac_nxt;

  always_comb begin
    dac_nxt = dac_r;
    if (!devrst_n) begin
      dac_nxt = DAC_RESET;
    end else if (wr_commit) begin
      dac_nxt = data_s;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prev_r     <= PIN_RESET[7:0];
      osc_cnt_r  <= 5'd0;
      osc_lvl_r  <= 1'b0;
      state_r    <= SAC_IDLE;
      cap_cnt_r  <= 4'd0;
      edge_cnt_r <= 4'd0;
      sar_r      <= SAR_CLEAR;
      result_r   <= RESULT_RESET;
      capture_r  <= 1'b0;
      busy_n_r   <= 1'b1;
      hold_r     <= 1'b0;
      int_n_r    <= 1'b1;
      dac_r      <= DAC_RESET;
    end else begin
      prev_r     <= prev_nxt;
      osc_cnt_r  <= osc_cnt_nxt;
      osc_lvl_r  <= osc_lvl_nxt;
      state_r    <= state_nxt;
      cap_cnt_r  <= cap_cnt_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      sar_r      <= sar_nxt;
      result_r   <= result_nxt;
      capture_r  <= capture_nxt;
      busy_n_r   <= busy_n_nxt;
      hold_r     <= hold_nxt;
      int_n_r    <= int_n_nxt;
      dac_r      <= dac_nxt;
    end
  end

  // old result stays on the bus until the new one is latched
  assign o_data                    = result_r;
  assign o_data_oe                 = rd_access;
  assign o_busy_n                  = busy_n_r;
  assign o_int_n                   = int_n_r;
  assign o_hold                    = hold_r;
  assign o_capture                 = capture_r;
  assign o_successive_approx_reg   = sar_r;
  assign o_dac_code                = dac_r;
  assign o_osc_timing_capacitor    = osc_lvl_r;
  assign o_osc_timing_capacitor_oe = osc_sel;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_conv_start;
    (state_r == SAC_IDLE) && start_req;
  endsequence

  sequence s_last_edge;
    (state_r == SAC_CONV) && conv_edge && (edge_cnt_r == CONV_EDGES);
  endsequence

  a_start_busy_low: assert property (
    s_conv_start |=> !o_busy_n && o_hold)
    else $error("start did not lower busy");
  a_capture_delay: assert property (
    s_conv_start |=> !o_capture [*8] ##1 !o_capture [*5] ##1 o_capture)
    else $error("input capture not at aperture delay");
  a_settle_no_count: assert property (
    (state_r == SAC_SETTLE) |=> (edge_cnt_r == 4'd0) && (sar_r == SAR_CLEAR))
    else $error("edge counted inside aperture window");
  a_msb_decision: assert property (
    (state_r == SAC_CONV) && conv_edge && (edge_cnt_r == 4'd1)
    |=> sar_r[7] == $past(cmp) && sar_r[6])
    else $error("msb decision wrong");
  a_result_latch: assert property (
    s_last_edge |=> result_r == $past(sar_try) && sar_r == SAR_CLEAR)
    else $error("result not latched or register not cleared");
  a_end_signals: assert property (
    s_last_edge |=> o_busy_n && !o_hold && !o_int_n)
    else $error("end of conversion outputs wrong");
  a_devrst_conv: assert property (
    !devrst_n && (state_r == SAC_CONV) && !conv_edge
    |=> (state_r == SAC_CONV) && $stable(sar_r) && $stable(edge_cnt_r))
    else $error("device reset disturbed conversion");
  a_devrst_int: assert property (
    !devrst_n && !done |=> o_int_n)
    else $error("device reset did not raise interrupt");
  a_read_clears_int: assert property (
    rd_access_end && !done |=> o_int_n)
    else $error("read end did not clear interrupt");
  a_dac_stable: assert property (
    devrst_n && !wr_commit |=> $stable(o_dac_code))
    else $error("dac register changed without edge");
  a_dac_reset: assert property (
    !devrst_n |=> o_dac_code == DAC_RESET)
    else $error("dac register not zeroed");
  a_osc_parked: assert property (
    osc_sel && (state_r == SAC_IDLE) |=> !o_osc_timing_capacitor)
    else $error("oscillator pin not at ground when idle");
  a_old_data: assert property (
    (state_r != SAC_IDLE) && !done |=> $stable(o_data))
    else $error("bus data changed during conversion");
endmodule
`default_nettype wire

// file: sim/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host_model #(
  parameter int CLK_HALF_NS = 80
) (
  input  wire logic                   i_capture,
  input  wire logic [sac_pkg::DW-1:0] i_trial,
  input  wire logic [sac_pkg::DW-1:0] i_analog,
  output logic                        o_conv_clk,
  output logic                        o_cmp_above
);
  logic [sac_pkg::DW-1:0] held_r;
  // external clock runs free between conversions, 50/50 duty
  initial begin
    o_conv_clk = 1'b1;
    forever #(CLK_HALF_NS) o_conv_clk = ~o_conv_clk;
  end
  // track/hold: later input changes must not reach the comparator
  initial held_r = 8'h00;
  always @(posedge i_capture) begin
    held_r <= i_analog;
  end
  always_comb begin
    o_cmp_above = (held_r >= i_trial);
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, rst_n, start_n, cs_n, rd_n, wr_n, dev_rst_n, osc_sel;
  logic [7:0] data_in, analog, prev;
  wire logic       ext_clk, cmp, pin, capture, busy_n, int_n, hold, data_oe, osc_o, osc_oe;
  wire logic [7:0] data_o, successive_approx_reg, dac;
  int fails, num_checks;

  // clock pin: device drives it only in internal mode
  assign pin = osc_oe ? osc_o : ext_clk;

  sac_core u_sac_core (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_start_convert_n(start_n), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_dev_reset_n(dev_rst_n), .i_int_osc_sel(osc_sel),
    .i_osc_timing_capacitor(pin), .i_cmp_above(cmp), .i_data(data_in), .o_data(data_o),
    .o_data_oe(data_oe), .o_busy_n(busy_n), .o_int_n(int_n), .o_hold(hold),
    .o_capture(capture), .o_successive_approx_reg(successive_approx_reg), .o_dac_code(dac),
    .o_osc_timing_capacitor(osc_o), .o_osc_timing_capacitor_oe(osc_oe));

  sac_host_model u_sac_host_model (
    .i_capture(capture), .i_trial(successive_approx_reg), .i_analog(analog),
    .o_conv_clk(ext_clk), .o_cmp_above(cmp));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic err(input string msg);
    fails++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) err(msg);
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) err(msg);
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n < 3000) begin
      cyc(1);
      n++;
    end
    if (n == 3000) err("busy wait timed out");
  endtask

  task automatic t_reset();
    chk1(busy_n, 1'b1, "busy after reset");
    chk1(int_n, 1'b1, "int after reset");
    chk(dac, 8'h00, "dac after reset");
    chk1(hold, 1'b0, "hold after reset");
  endtask

  task automatic t_dac(input logic [7:0] v);
    data_in = v;
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(8);
    chk(dac, 8'h00, "dac open while strobes low");
    wr_n = 1'b1;
    cyc(6);
    cs_n = 1'b1;
    chk(dac, v, "dac not loaded on write rise");
    data_in = 8'h11;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(6);
    chk(dac, v, "dac loaded without select");
  endtask

  // fl[0]: device reset pulse mid-run, fl[1]: refused restart mid-run
  task automatic t_conv(input bit mode2, input logic [7:0] v, input int p, input bit [1:0] fl);
    realtime t0;
    int len;
    analog = v;
    t0 = $realtime;
    if (mode2) begin
      cs_n = 1'b0;
      rd_n = 1'b0;
    end else begin
      start_n = 1'b0;
      cyc(4);
      start_n = 1'b1;
    end
    wait_busy(1'b0);
    chk1(hold, 1'b1, "no hold at start");
    if (mode2) chk1(data_oe, 1'b1, "bus not driven in read start");
    if (mode2) chk(data_o, prev, "old result not on bus");
    cyc(20);
    analog = ~v;
    if (fl[1]) begin
      start_n = 1'b0;
      cyc(4);
      start_n = 1'b1;
    end
    if (fl[0]) begin
      dev_rst_n = 1'b0;
      cyc(10);
      chk(dac, 8'h00, "dac not zeroed by device reset");
      chk1(int_n, 1'b1, "int not raised by device reset");
      chk1(busy_n, 1'b0, "device reset stopped conversion");
      dev_rst_n = 1'b1;
    end
    wait_busy(1'b1);
    len = int'(($realtime - t0) / 4.0);
    if (len < 8 * p + 14 || len > 9 * p + 34) err("conversion length");
    num_checks++;
    chk(data_o, v, "wrong result");
    chk(successive_approx_reg, 8'h00, "sar not cleared");
    chk1(hold, 1'b0, "still in hold");
    chk1(int_n, 1'b0, "no interrupt at end");
    prev = v;
    if (mode2) begin
      chk1(data_oe, 1'b1, "bus released early");
      cs_n = 1'b1;
      rd_n = 1'b1;
      cyc(6);
      chk1(int_n, 1'b1, "int not cleared by read end");
    end
    cyc(700); // keeps start rate under 400 kHz
  endtask

  // select and read low is itself a start: old result shown, then a conversion
  task automatic t_read(input logic [7:0] v);
    cs_n = 1'b0;
    rd_n = 1'b0;
    cyc(4);
    chk1(data_oe, 1'b1, "bus not driven on read");
    chk(data_o, v, "read data");
    rd_n = 1'b1;
    cs_n = 1'b1;
    cyc(6);
    chk1(int_n, 1'b1, "int not cleared by read");
    chk1(busy_n, 1'b0, "read did not start conversion");
    wait_busy(1'b1);
    chk(data_o, analog, "read-started result wrong");
    prev = analog;
    cyc(700);
  endtask

  task automatic t_intosc(input logic [7:0] v);
    osc_sel = 1'b1;
    cyc(5);
    chk1(osc_oe, 1'b1, "clock pin not driven");
    t_conv(1'b0, v, 62, 2'b10);
    chk1(osc_o, 1'b0, "oscillator not stopped");
    cyc(40);
    chk1(osc_o, 1'b0, "oscillator restarted idle");
  endtask

  initial begin
    {start_n, cs_n, rd_n, wr_n, dev_rst_n} = 5'h1f;
    {osc_sel, rst_n} = 2'b00;
    data_in = 8'h00;
    analog = 8'h00;
    prev = 8'h00;
    fails = 0;
    num_checks = 0;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_dac(8'h5a);
    t_conv(1'b0, 8'ha5, 40, 2'b00);
    t_conv(1'b0, 8'h3c, 40, 2'b01);
    t_read(8'h3c);
    t_conv(1'b1, 8'hff, 40, 2'b00);
    t_conv(1'b1, 8'h00, 40, 2'b00);
    t_intosc(8'h69);
    finish_test();
  end

  initial begin
    #200us;
    err("watchdog expired");
    finish_test();
  end
endmodule
`default_nettype wire
